// ### core/fbr_device.sv
// flash end: boot read, boot config register commands and sector relock
`timescale 1ns/1ps
// How it works
// - relock closes the one open sector
// - other sectors of block stay read-only
// - reset arms boot read at start address
// - host fetches boot data by select and clock
// - output held for start-delay count cycles
// - host sends no command during delay
// - quad enable picks quad or single format
// - host clock at most 133 MHz
// - first boot byte from start address field
// - boot data streams sequentially while selected
// - select rise after first byte ends boot
// - host reads at least one whole byte
// - no boot read again until reset
// - boot read only when enable bit set
// - boot config register survives power loss
// - config read: low byte first, MSB first
// - further clocks repeat the config word
// - config write needs write enable latch set
// - host sends 32 bits, low byte first
// - write runs only if select rises after 32
// - write in progress high during write
// - write completion clears write enable latch
// - open takes address, one sector at once
module fbr_device #(
  parameter int MEM_AW = 8,
  parameter int WRITE_CYCLES = fbr_pkg::WR_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  fbr_spi_if.dev spi,
  input wire logic quad_enable_i,
  input wire logic block_protected_i,
  input wire logic [fbr_pkg::ADR_W-1:0] check_addr_i,
  input wire logic mem_we_i,
  input wire logic [MEM_AW-1:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic write_enable_latch_o,
  output logic write_in_progress_o,
  output logic [fbr_pkg::CFG_W-1:0] boot_cfg_o,
  output logic sector_open_o,
  output logic [fbr_pkg::SEC_W-1:0] open_sector_o,
  output logic check_writable_o,
  output logic boot_active_o
);
  import fbr_pkg::*;
  localparam int WCW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CFG_W-9:0] PAD = '0;

  logic [7:0] mem [2**MEM_AW];
  logic [5:0] pin;
  logic cs_n, sck, rise, cs_fall, cs_rise, quad;
  logic cs_prev_q, sck_prev_q;
  logic [OP_W-1:0] op;
  logic [CFG_DLY_W-1:0] dly;
  fbr_dst_e st_q, st_d;
  logic [5:0] bc_q, bc_d;
  logic [CFG_W-1:0] sh_q, sh_d, wbuf_q, wbuf_d, cfg_d;
  logic [CFG_W-1:0] cfg_q = CFG_INIT;
  logic [ADR_W-1:0] adr_q, adr_d;
  logic [CFG_DLY_W-1:0] dc_q, dc_d;
  logic [WCW-1:0] wc_q, wc_d;
  logic [SEC_W-1:0] sec_q, sec_d;
  logic done_q, done_d, wel_q, wel_d, wip_q, wip_d, open_q, open_d;
  logic rsten_q, rsten_d, rstp_q, rstp_d, chk_q, chk_d, act_q, act_d;
  logic [3:0] dout_q, dout_d, doe_q, doe_d;

  fbr_sync #(.W(6), .RST(PIN_RST)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({spi.cs_n, spi.sck, spi.io}),
    .q_o(pin)
  );

  assign cs_n = pin[5];
  assign sck = pin[4];
  assign rise = sck & ~sck_prev_q & ~cs_n;
  assign cs_fall = ~cs_n & cs_prev_q;
  assign cs_rise = cs_n & ~cs_prev_q;
  assign quad = quad_enable_i;
  assign op = {sh_q[OP_W-2:0], pin[0]};
  assign dly = cfg_q[CFG_DLY_LSB +: CFG_DLY_W];

  always_comb begin
    st_d = st_q;
    bc_d = bc_q;
    sh_d = sh_q;
    wbuf_d = wbuf_q;
    cfg_d = cfg_q;
    adr_d = adr_q;
    dc_d = dc_q;
    wc_d = wc_q;
    sec_d = sec_q;
    done_d = done_q;
    wel_d = wel_q;
    wip_d = wip_q;
    open_d = open_q;
    rsten_d = rsten_q;
    rstp_d = rstp_q;
    if (wip_q) begin
      if (wc_q == '0) begin
        wip_d = 1'b0;
        wel_d = 1'b0;
        cfg_d = wbuf_q;
      end else begin
        wc_d = wc_q - 1'b1;
      end
    end
    case (st_q)
      DS_ARM: begin
        if (cs_fall) begin
          st_d = (dly == '0) ? DS_DATA : DS_DLY;
          sh_d = {mem[adr_q[MEM_AW-1:0]], PAD};
          adr_d = adr_q + 1'b1;
          dc_d = '0;
          bc_d = '0;
        end
      end
      DS_DLY: begin
        if (rise) begin
          if (dc_q == dly - 1'b1) begin
            st_d = DS_DATA;
          end else begin
            dc_d = dc_q + 1'b1;
          end
        end
      end
      DS_DATA: begin
        if (rise) begin
          sh_d = quad ? (sh_q << QUAD_W) : (sh_q << 1);
          bc_d = bc_q + (quad ? 6'(QUAD_W) : 6'd1);
          if (bc_d == 6'(OP_W)) begin
            sh_d = {mem[adr_q[MEM_AW-1:0]], PAD};
            adr_d = adr_q + 1'b1;
            bc_d = '0;
            done_d = 1'b1;
          end
        end
      end
      DS_IDLE: begin
        if (cs_fall) begin
          st_d = DS_OPC;
          bc_d = '0;
        end
      end
      DS_OPC: begin
        if (rise) begin
          sh_d = {sh_q[CFG_W-2:0], pin[0]};
          bc_d = bc_q + 6'd1;
          if (bc_q == 6'(OP_W - 1)) begin
            st_d = DS_SKIP;
            bc_d = '0;
            rsten_d = 1'b0;
            if (op == OP_WRITE_ENABLE_CMD) begin
              wel_d = 1'b1;
            end else if (op == OP_RELOCK) begin
              open_d = 1'b0;
            end else if (op == OP_OPEN) begin
              st_d = DS_ADDR;
            end else if (op == OP_CFG_RD) begin
              st_d = DS_RD;
              sh_d = fbr_bswap(cfg_q);
            end else if (op == OP_CFG_WR && wel_q && !wip_q) begin
              st_d = DS_WR;
            end else if (op == OP_RST_EN) begin
              rsten_d = 1'b1;
            end else if (op == OP_RST) begin
              rstp_d = rsten_q;
            end
          end
        end
      end
      DS_ADDR: begin
        if (rise) begin
          sh_d = {sh_q[CFG_W-2:0], pin[0]};
          bc_d = bc_q + 6'd1;
          if (bc_q == 6'(ADR_W - 1)) begin
            st_d = DS_SKIP;
            if (!open_q) begin
              open_d = 1'b1;
              sec_d = sh_d[SEC_LSB +: SEC_W];
            end
          end
        end
      end
      DS_RD: begin
        if (rise) begin
          if (bc_q == 6'(CFG_W - 1)) begin
            sh_d = fbr_bswap(cfg_q);
            bc_d = '0;
          end else begin
            sh_d = sh_q << 1;
            bc_d = bc_q + 6'd1;
          end
        end
      end
      DS_WR: begin
        if (rise) begin
          sh_d = {sh_q[CFG_W-2:0], pin[0]};
          if (bc_q != 6'(CFG_W + 1)) begin
            bc_d = bc_q + 6'd1;
          end
        end
      end
      default: begin
      end
    endcase
    if (cs_rise) begin
      if (st_q == DS_DLY || st_q == DS_DATA) begin
        st_d = done_q ? DS_IDLE : DS_ARM;
        adr_d = cfg_q[CFG_ADR_LSB +: ADR_W];
      end else if (st_q != DS_ARM) begin
        st_d = DS_IDLE;
        if (st_q == DS_WR && bc_q == 6'(CFG_W)) begin
          wip_d = 1'b1;
          wc_d = WCW'(WRITE_CYCLES - 1);
          wbuf_d = fbr_bswap(sh_q);
        end
      end
    end
    if (srst_i || (cs_rise && rstp_q)) begin
      st_d = cfg_q[CFG_EN_BIT] ? DS_ARM : DS_IDLE;
      adr_d = cfg_q[CFG_ADR_LSB +: ADR_W];
      done_d = 1'b0;
      rstp_d = 1'b0;
      rsten_d = 1'b0;
      bc_d = '0;
    end
    if (srst_i) begin
      wel_d = 1'b0;
      wip_d = 1'b0;
      wc_d = '0;
      open_d = 1'b0;
      sec_d = '0;
      sh_d = '0;
      dc_d = '0;
      wbuf_d = '0;
    end
    act_d = (st_d == DS_ARM) || (st_d == DS_DLY) || (st_d == DS_DATA);
    chk_d = !block_protected_i || (open_q && check_addr_i[SEC_LSB +: SEC_W] == sec_q);
    if (st_d == DS_DATA) begin
      doe_d = quad ? IO_QUAD : IO_SO;
    end else if (st_d == DS_RD) begin
      doe_d = IO_SO;
    end else begin
      doe_d = '0;
    end
    if (st_d == DS_DATA && quad) begin
      dout_d = sh_d[CFG_W-1 -: QUAD_W];
    end else begin
      dout_d = {2'b00, sh_d[CFG_W-1], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    st_q <= st_d;
    bc_q <= bc_d;
    sh_q <= sh_d;
    wbuf_q <= wbuf_d;
    adr_q <= adr_d;
    dc_q <= dc_d;
    wc_q <= wc_d;
    sec_q <= sec_d;
    done_q <= done_d;
    wel_q <= wel_d;
    wip_q <= wip_d;
    open_q <= open_d;
    rsten_q <= rsten_d;
    rstp_q <= rstp_d;
    act_q <= srst_i ? 1'b0 : act_d;
    chk_q <= srst_i ? 1'b0 : chk_d;
    doe_q <= srst_i ? 4'h0 : doe_d;
    dout_q <= srst_i ? 4'h0 : dout_d;
    cs_prev_q <= srst_i ? 1'b1 : cs_n;
    sck_prev_q <= srst_i ? 1'b0 : sck;
  end

  // non-volatile contents: no reset touches them
  always_ff @(posedge clk_i) begin
    cfg_q <= cfg_d;
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end

  assign spi.dev_io_o = dout_q;
  assign spi.dev_io_oe = doe_q;
  assign write_enable_latch_o = wel_q;
  assign write_in_progress_o = wip_q;
  assign boot_cfg_o = cfg_q;
  assign sector_open_o = open_q;
  assign open_sector_o = sec_q;
  assign check_writable_o = chk_q;
  assign boot_active_o = act_q;
endmodule

// ### core/fbr_pkg.sv
// shared constants, types and helpers for the boot read and sector relock logic
package fbr_pkg;
  localparam int CLK_MHZ = 250;
  localparam int SCK_MAX_MHZ = 133;
  localparam int SCK_MIN_HALF = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int WR_TIME_NS = 2000;
  localparam int WR_CYC = WR_TIME_NS * CLK_MHZ / 1000;
  localparam int OP_W = 8;
  localparam int ADR_W = 24;
  localparam int CFG_W = 32;
  localparam int TX_W = OP_W + CFG_W;
  localparam int QUAD_W = 4;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_DLY_LSB = 1;
  localparam int CFG_DLY_W = 4;
  localparam int CFG_ADR_LSB = 8;
  localparam int SEC_LSB = 12;
  localparam int SEC_W = 12;
  localparam logic [CFG_W-1:0] CFG_INIT = 32'h0000_0000;
  localparam logic [5:0] PIN_RST = 6'h20;
  localparam logic [3:0] IO_SO = 4'h2;
  localparam logic [3:0] IO_QUAD = 4'hf;
  localparam logic [OP_W-1:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [OP_W-1:0] OP_RELOCK = 8'h24;
  localparam logic [OP_W-1:0] OP_OPEN = 8'h26;
  localparam logic [OP_W-1:0] OP_CFG_RD = 8'h14;
  localparam logic [OP_W-1:0] OP_CFG_WR = 8'h15;
  localparam logic [OP_W-1:0] OP_RST_EN = 8'h66;
  localparam logic [OP_W-1:0] OP_RST = 8'h99;

  typedef enum logic [3:0] {
    DS_IDLE = 4'h0,
    DS_OPC = 4'h1,
    DS_ADDR = 4'h2,
    DS_RD = 4'h3,
    DS_WR = 4'h4,
    DS_SKIP = 4'h5,
    DS_ARM = 4'h6,
    DS_DLY = 4'h7,
    DS_DATA = 4'h8
  } fbr_dst_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_SEL = 2'h1,
    HS_RUN = 2'h2,
    HS_GAP = 2'h3
  } fbr_hst_e;

  typedef enum logic [2:0] {
    HC_BOOT = 3'h0,
    HC_WRITE_ENABLE_CMD = 3'h1,
    HC_RELOCK = 3'h2,
    HC_OPEN = 3'h3,
    HC_CFG_RD = 3'h4,
    HC_CFG_WR = 3'h5,
    HC_RESET = 3'h6
  } fbr_cmd_e;

  function automatic logic [CFG_W-1:0] fbr_bswap(input logic [CFG_W-1:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// ### core/fbr_spi_if.sv
// serial link between host and flash: select, clock and four data lines
`timescale 1ns/1ps
interface fbr_spi_if;
  logic cs_n;
  logic sck;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;
  // undriven lines float high
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o) |
              (~dev_io_oe & ~host_io_oe);
  modport host (output cs_n, output sck, output host_io_o, output host_io_oe, input io);
  modport dev (input cs_n, input sck, input io, output dev_io_o, output dev_io_oe);
endinterface

// ### core/fbr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fbr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= RST;
      q_o <= RST;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ### core/fbr_host.sv
// host end: drives select and clock, sends commands, fetches boot data
`timescale 1ns/1ps
module fbr_host #(
  parameter int SCK_HALF = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  fbr_spi_if.host spi,
  input wire logic cmd_valid_i,
  input wire fbr_pkg::fbr_cmd_e cmd_i,
  input wire logic [fbr_pkg::ADR_W-1:0] cmd_addr_i,
  input wire logic [fbr_pkg::CFG_W-1:0] cmd_data_i,
  input wire logic [7:0] rd_bytes_i,
  input wire logic [fbr_pkg::CFG_DLY_W-1:0] boot_delay_i,
  input wire logic quad_i,
  output logic ready_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o
);
  import fbr_pkg::*;
  localparam int HALF = (SCK_HALF < SCK_MIN_HALF) ? SCK_MIN_HALF : SCK_HALF;
  localparam int DW = $clog2(HALF + 1);
  localparam logic [CFG_W-1:0] ZW = '0;

  logic [3:0] io_s;
  logic tick, go;
  logic [7:0] nb;
  logic [10:0] tot_tx;
  fbr_hst_e st_q, st_d;
  logic [DW-1:0] div_q, div_d;
  logic cs_q, cs_d, sck_q, sck_d, oe_q, oe_d, out_q, out_d;
  logic [TX_W-1:0] tx_q, tx_d, ptx_q, ptx_d;
  logic [5:0] txn_q, txn_d, ptxn_q, ptxn_d;
  logic [CFG_DLY_W-1:0] skip_q, skip_d;
  logic [10:0] rxn_q, rxn_d, cyc_q, cyc_d;
  logic rxq_q, rxq_d, pend_q, pend_d, rdy_q, rdy_d, rxv_q, rxv_d;
  logic [7:0] rxsh_q, rxsh_d, rxb_q, rxb_d;
  logic [2:0] rxc_q, rxc_d;

  fbr_sync #(.W(4), .RST(4'h0)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(spi.io),
    .q_o(io_s)
  );

  assign tick = div_q == DW'(HALF - 1);
  assign nb = (rd_bytes_i == 8'h00) ? 8'h01 : rd_bytes_i;
  assign tot_tx = 11'(txn_q) + 11'(skip_q);

  always_comb begin
    st_d = st_q;
    div_d = tick ? '0 : div_q + 1'b1;
    cs_d = cs_q;
    sck_d = sck_q;
    oe_d = oe_q;
    out_d = out_q;
    tx_d = tx_q;
    txn_d = txn_q;
    ptx_d = ptx_q;
    ptxn_d = ptxn_q;
    skip_d = skip_q;
    rxn_d = rxn_q;
    cyc_d = cyc_q;
    rxq_d = rxq_q;
    pend_d = pend_q;
    rxsh_d = rxsh_q;
    rxb_d = rxb_q;
    rxc_d = rxc_q;
    rxv_d = 1'b0;
    go = 1'b0;
    case (st_q)
      HS_IDLE: begin
        if (pend_q || cmd_valid_i) begin
          go = 1'b1;
          tx_d = ptx_q;
          txn_d = ptxn_q;
          skip_d = '0;
          rxn_d = '0;
          rxq_d = 1'b0;
          pend_d = 1'b0;
        end
        if (!pend_q && cmd_valid_i) begin
          txn_d = 6'(OP_W);
          case (cmd_i)
            HC_BOOT: begin
              txn_d = '0;
              skip_d = boot_delay_i;
              rxq_d = quad_i;
              rxn_d = 11'(nb) << (quad_i ? 1 : 3);
            end
            HC_WRITE_ENABLE_CMD: tx_d = {OP_WRITE_ENABLE_CMD, ZW};
            HC_RELOCK: tx_d = {OP_RELOCK, ZW};
            HC_OPEN: begin
              tx_d = {OP_OPEN, cmd_addr_i, ZW[CFG_W-ADR_W-1:0]};
              txn_d = 6'(OP_W + ADR_W);
            end
            HC_CFG_RD: begin
              tx_d = {OP_CFG_RD, ZW};
              rxn_d = 11'(nb) << 3;
            end
            HC_CFG_WR: begin
              tx_d = {OP_WRITE_ENABLE_CMD, ZW};
              pend_d = 1'b1;
              ptx_d = {OP_CFG_WR, fbr_bswap(cmd_data_i)};
              ptxn_d = 6'(TX_W);
            end
            default: begin
              tx_d = {OP_RST_EN, ZW};
              pend_d = 1'b1;
              ptx_d = {OP_RST, ZW};
              ptxn_d = 6'(OP_W);
            end
          endcase
        end
      end
      HS_SEL: begin
        if (tick) begin
          st_d = HS_RUN;
        end
      end
      HS_RUN: begin
        if (tick && !sck_q) begin
          sck_d = 1'b1;
          cyc_d = cyc_q + 1'b1;
          if (cyc_q >= tot_tx) begin
            rxsh_d = rxq_q ? {rxsh_q[3:0], io_s} : {rxsh_q[6:0], io_s[1]};
            rxc_d = rxc_q + (rxq_q ? 3'(QUAD_W) : 3'd1);
            if (rxc_d == '0) begin
              rxv_d = 1'b1;
              rxb_d = rxsh_d;
            end
          end
        end else if (tick) begin
          sck_d = 1'b0;
          if (cyc_q == tot_tx + rxn_q) begin
            cs_d = 1'b1;
            oe_d = 1'b0;
            st_d = HS_GAP;
          end else begin
            tx_d = tx_q << 1;
            out_d = tx_d[TX_W-1];
            oe_d = cyc_q < 11'(txn_q);
          end
        end
      end
      default: begin
        if (tick) begin
          st_d = HS_IDLE;
        end
      end
    endcase
    if (go) begin
      st_d = HS_SEL;
      div_d = '0;
      cs_d = 1'b0;
      sck_d = 1'b0;
      cyc_d = '0;
      rxc_d = '0;
      oe_d = txn_d != '0;
      out_d = tx_d[TX_W-1];
    end
    if (srst_i) begin
      st_d = HS_IDLE;
      div_d = '0;
      cs_d = 1'b1;
      sck_d = 1'b0;
      oe_d = 1'b0;
      pend_d = 1'b0;
      rxv_d = 1'b0;
    end
    rdy_d = (st_d == HS_IDLE) && !pend_d;
  end

  always_ff @(posedge clk_i) begin
    st_q <= st_d;
    div_q <= div_d;
    cs_q <= cs_d;
    sck_q <= sck_d;
    oe_q <= oe_d;
    out_q <= out_d;
    tx_q <= tx_d;
    txn_q <= txn_d;
    ptx_q <= ptx_d;
    ptxn_q <= ptxn_d;
    skip_q <= skip_d;
    rxn_q <= rxn_d;
    cyc_q <= cyc_d;
    rxq_q <= rxq_d;
    pend_q <= pend_d;
    rxsh_q <= rxsh_d;
    rxb_q <= srst_i ? 8'h00 : rxb_d;
    rxc_q <= rxc_d;
    rxv_q <= rxv_d;
    rdy_q <= rdy_d;
  end

  assign spi.cs_n = cs_q;
  assign spi.sck = sck_q;
  assign spi.host_io_o = {3'b000, out_q};
  assign spi.host_io_oe = {3'b000, oe_q};
  assign ready_o = rdy_q;
  assign rx_byte_o = rxb_q;
  assign rx_valid_o = rxv_q;
endmodule

// ### test/fbr_link_sva.sv
// link checker for the serial wire between host and flash ends
`timescale 1ns/1ps
module fbr_link_sva
  import fbr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_SCK_QUIET: assert property (cs_n |-> !sck)
    else $error("serial clock moves while deselected");
  AST_HOST_SELECTED: assert property (host_io_oe[0] |-> !cs_n)
    else $error("host drives data line while deselected");
  AST_HOST_ONE_LINE: assert property (host_io_oe[3:1] == 3'h0)
    else $error("host drives an upper data line");
  AST_NO_CLASH: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("host and flash drive a line together");
  AST_SCK_HIGH_HOLD: assert property ($rose(sck) |=> $stable(sck)[*3])
    else $error("serial clock high phase too short");
  AST_SCK_LOW_HOLD: assert property ($fell(sck) |=> $stable(sck)[*3])
    else $error("serial clock low phase too short");
  AST_FORMAT: assert property (dev_io_oe == 4'h0 || dev_io_oe == IO_SO || dev_io_oe == IO_QUAD)
    else $error("flash drives an illegal line set");
  AST_RELEASE: assert property (cs_n[*5] |-> dev_io_oe == 4'h0)
    else $error("flash still drives after deselect");
  AST_STREAM_HOLD: assert property ($fell(sck) |=>
    (dev_io_oe == 4'h0 || $stable(dev_io_o))[*3])
    else $error("flash output changes during low clock phase");
  AST_FRAME_START: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0)[*2])
    else $error("flash drives at frame start");

  cover property (dev_io_oe == IO_QUAD);
  cover property (dev_io_oe == IO_SO);
  cover property ($rose(cs_n));
endmodule

// ### test/tb_top.sv
// self-checking bench for host and flash ends joined by the serial link
`timescale 1ns/1ps
module tb_top;
  import fbr_pkg::*;
  typedef struct {fbr_cmd_e c; logic [23:0] a; logic wl; logic op; logic [11:0] sec;
    logic w7; logic w8;} fbr_row_s;
  logic clk, srst, cmd_valid, quad, qe, bprot, mem_we, write_enable_latch, write_in_progress, sopen, cwr, bact, rxv, rdy;
  logic wip_seen;
  fbr_cmd_e cmd;
  logic [23:0] caddr, chk_addr;
  logic [31:0] cdata, cfg;
  logic [7:0] nby, maddr, mdata, rxb;
  logic [3:0] dly;
  logic [11:0] osec;
  int num_errors, n_compared;
  logic [7:0] rxq[$];
  fbr_row_s rows[6] = '{
    '{HC_WRITE_ENABLE_CMD, 24'h000000, 1'b1, 1'b0, 12'h000, 1'b0, 1'b0},
    '{HC_OPEN, 24'h007123, 1'b1, 1'b1, 12'h007, 1'b1, 1'b0},
    '{HC_OPEN, 24'h008000, 1'b1, 1'b1, 12'h007, 1'b1, 1'b0},
    '{HC_RELOCK, 24'h000000, 1'b1, 1'b0, 12'h000, 1'b0, 1'b0},
    '{HC_OPEN, 24'h008fff, 1'b1, 1'b1, 12'h008, 1'b0, 1'b1},
    '{HC_RELOCK, 24'h000000, 1'b1, 1'b0, 12'h000, 1'b0, 1'b0}};

  fbr_spi_if spi_if();
  fbr_device #(.MEM_AW(8), .WRITE_CYCLES(8)) fbr_device_i (.clk_i(clk), .srst_i(srst),
    .spi(spi_if), .quad_enable_i(qe), .block_protected_i(bprot), .check_addr_i(chk_addr),
    .mem_we_i(mem_we), .mem_addr_i(maddr), .mem_wdata_i(mdata), .write_enable_latch_o(write_enable_latch),
    .write_in_progress_o(write_in_progress), .boot_cfg_o(cfg), .sector_open_o(sopen), .open_sector_o(osec),
    .check_writable_o(cwr), .boot_active_o(bact));
  fbr_host #(.SCK_HALF(4)) fbr_host_i (.clk_i(clk), .srst_i(srst), .spi(spi_if),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_addr_i(caddr), .cmd_data_i(cdata),
    .rd_bytes_i(nby), .boot_delay_i(dly), .quad_i(quad), .ready_o(rdy), .rx_byte_o(rxb),
    .rx_valid_o(rxv));
  fbr_link_sva fbr_link_sva_i (.clk_i(clk), .srst_i(srst), .cs_n(spi_if.cs_n),
    .sck(spi_if.sck), .host_io_oe(spi_if.host_io_oe), .dev_io_o(spi_if.dev_io_o),
    .dev_io_oe(spi_if.dev_io_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rxv === 1'b1) rxq.push_back(rxb);
    if (write_in_progress === 1'b1) wip_seen = 1'b1;
  end

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < 5000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 5000) num_errors++;
  endtask

  task automatic run(input fbr_cmd_e c, input logic [23:0] a, input logic [31:0] d,
                     input logic [7:0] n, input logic q);
    wait_ready();
    rxq.delete();
    cmd = c;
    caddr = a;
    cdata = d;
    nby = n;
    quad = q;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
    wait_ready();
    repeat (4) @(negedge clk);
  endtask

  task automatic cfg_write(input logic [31:0] w);
    wip_seen = 1'b0;
    run(HC_CFG_WR, 24'h0, w, 8'h1, 1'b0);
    repeat (16) @(negedge clk);
    chk_bit(wip_seen, 1'b1);
    chk_bit(write_in_progress, 1'b0);
    chk_bit(write_enable_latch, 1'b0);
    chk_word(cfg, w);
  endtask

  task automatic chk_boot(input int n);
    chk_word(32'(rxq.size()), 32'(n));
    for (int i = 0; i < n; i++) chk_word({24'h0, rxq[i]}, {24'h0, 8'(i + 16) ^ 8'h3c});
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd = HC_WRITE_ENABLE_CMD;
    caddr = '0;
    cdata = '0;
    nby = 8'h1;
    dly = 4'h3;
    quad = 1'b0;
    qe = 1'b0;
    bprot = 1'b1;
    chk_addr = '0;
    mem_we = 1'b0;
    maddr = '0;
    mdata = '0;
    wip_seen = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem_we = 1'b1;
      maddr = i[7:0];
      mdata = i[7:0] ^ 8'h3c;
      @(negedge clk);
    end
    mem_we = 1'b0;
    chk_bit(bact, 1'b0);
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].a, 32'h0, 8'h1, 1'b0);
      chk_bit(write_enable_latch, rows[i].wl);
      chk_bit(sopen, rows[i].op);
      if (rows[i].op) chk_word({20'h0, osec}, {20'h0, rows[i].sec});
      chk_addr = 24'h007abc;
      repeat (2) @(negedge clk);
      chk_bit(cwr, rows[i].w7);
      chk_addr = 24'h008001;
      repeat (2) @(negedge clk);
      chk_bit(cwr, rows[i].w8);
    end
    bprot = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(cwr, 1'b1);
    bprot = 1'b1;
    cfg_write(32'h0000_1007);
    run(HC_CFG_RD, 24'h0, 32'h0, 8'h8, 1'b0);
    chk_word(32'(rxq.size()), 32'h8);
    for (int i = 0; i < 8; i++) chk_word({24'h0, rxq[i]}, (32'h1007 >> (8 * (i % 4))) & 32'hff);
    run(HC_RESET, 24'h0, 32'h0, 8'h1, 1'b0);
    chk_bit(bact, 1'b1);
    run(HC_BOOT, 24'h0, 32'h0, 8'h3, 1'b0);
    chk_boot(3);
    chk_bit(bact, 1'b0);
    run(HC_WRITE_ENABLE_CMD, 24'h0, 32'h0, 8'h1, 1'b0);
    chk_bit(bact, 1'b0);
    run(HC_OPEN, 24'h00a000, 32'h0, 8'h1, 1'b0);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(write_enable_latch, 1'b0);
    chk_bit(sopen, 1'b0);
    chk_bit(write_in_progress, 1'b0);
    chk_word(cfg, 32'h0000_1007);
    chk_bit(bact, 1'b1);
    qe = 1'b1;
    run(HC_BOOT, 24'h0, 32'h0, 8'h2, 1'b1);
    chk_boot(2);
    qe = 1'b0;
    cfg_write(32'h0000_1001);
    run(HC_RESET, 24'h0, 32'h0, 8'h1, 1'b0);
    dly = 4'h0;
    run(HC_BOOT, 24'h0, 32'h0, 8'h1, 1'b0);
    chk_boot(1);
    chk_bit(bact, 1'b0);
    cfg_write(32'h0000_1006);
    run(HC_RESET, 24'h0, 32'h0, 8'h1, 1'b0);
    chk_bit(bact, 1'b0);
    tally_and_finish();
  end
endmodule
